// ==== pla_pkg.sv ====
// Shared constants, types and helpers for the sum-of-products array
package pla_pkg;

	localparam int NUM_LINES = 16;
	localparam int NUM_TERMS = 64;
	localparam int NUM_CELLS = 8;
	localparam int TERMS_PER_CELL = 8;
	localparam int NUM_DED = 8;
	localparam int WORD_W = 32;
	localparam int ADR_W = 9;
	localparam int IDX_W = 6;

	localparam logic [8:0] ARRAY_BASE = 9'h000;
	localparam logic [8:0] ARCH_ADDR = 9'h100;
	localparam logic [8:0] STATUS_ADDR = 9'h104;
	localparam int ARRAY_SEL_BIT = 8;
	localparam int IDX_LSB = 2;

	localparam int ARCH_MODE_LSB = 0;
	localparam int ARCH_SEL_LSB = 8;
	localparam int ARCH_POL_LSB = 16;
	localparam int STAT_PIN_LSB = 0;
	localparam int STAT_OE_LSB = 8;
	localparam int STAT_FF_LSB = 16;
	localparam int STAT_MODE_LSB = 24;

	localparam logic [31:0] ARRAY_RESET = 32'hFFFFFFFF;
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [7:0] POL_RESET = 8'hFF;
	localparam logic [7:0] FF_RESET = 8'h00;
	localparam logic [7:0] PIN_RESET = 8'h00;
	localparam logic [7:0] OE_N_RESET = 8'hFF;
	localparam logic CLK_PIN_RESET = 1'b1;

	typedef enum logic [2:0] {
		MODE_NARROW = 3'b001,
		MODE_REG = 3'b010,
		MODE_WIDE = 3'b100
	} mode_e;

	typedef enum logic [4:0] {
		CELL_INPUT = 5'b00001,
		CELL_OUTPUT = 5'b00010,
		CELL_REG = 5'b00100,
		CELL_IO = 5'b01000,
		CELL_TRI = 5'b10000
	} cell_e;

	typedef struct packed {
		mode_e mode;
		logic [7:0] sel;
		logic [7:0] act_high;
	} arch_s;

	typedef struct packed {
		logic sum8;
		logic sum7;
		logic gate;
	} sop_s;

	localparam arch_s ARCH_RESET = '{mode: MODE_NARROW, sel: SEL_RESET, act_high: POL_RESET};

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// ==== and_array_cells.sv ====
// Configuration cell storage of the AND array, one word per product term
`timescale 1ns/100ps
`default_nettype none
module and_array_cells (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Write port
	input wire logic we_i,
	input wire logic [5:0] idx_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] sel_i,
	// Whole array, straight from the cells
	output logic [63:0][31:0] cells_o
);

	logic [63:0][31:0] cells_q;
	logic [63:0][31:0] cells_d;

	always_comb begin
		cells_d = cells_q;
		if (we_i) begin
			cells_d[idx_i] = pla_pkg::merge_bytes(cells_q[idx_i], wdata_i, sel_i);
		end
	end

	// All cells connected after reset, so every term is false
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cells_q <= {pla_pkg::NUM_TERMS{pla_pkg::ARRAY_RESET}};
		end else begin
			cells_q <= cells_d;
		end
	end

	assign cells_o = cells_q;

endmodule
`default_nettype wire

// ==== sop_group.sv ====
// One group of eight product terms and its OR sums
`timescale 1ns/100ps
`default_nettype none
module sop_group (
	// Cells of the eight terms
	input wire logic [7:0][31:0] cells_i,
	// Array input lines
	input wire logic [15:0] lines_i,
	// Sums and gating term
	output pla_pkg::sop_s sop_o
);

	// Bits 15:0 connect true lines, bits 31:16 complement lines
	function automatic logic term_true(input logic [31:0] c, input logic [15:0] l);
		return &(~c[15:0] | l) & &(~c[31:16] | ~l);
	endfunction

	logic [7:0] terms;

	always_comb begin
		for (int t = 0; t < pla_pkg::TERMS_PER_CELL; t++) begin
			terms[t] = term_true(cells_i[t], lines_i);
		end
		sop_o.sum8 = |terms;
		sop_o.sum7 = |terms[7:1];
		sop_o.gate = terms[0];
	end

endmodule
`default_nettype wire

// ==== sop_array.sv ====
// Top of the programmable sum-of-products array with its register slave
//
// Summary of operation
// - Sixteen lines, true and complement, cross 64 terms: 2048 cells.
// - Each cell connects or leaves off one line phase to its term.
// - A term is true only while all its connected line phases are high.
// - Terms split into eight groups of eight, one per macrocell.
// - Seven or eight terms ORed; with seven, the spare term gates the driver.
// - Registered cells capture their function on the clock pin rising edge.
// - Per-cell polarity, applied ahead of the flip-flop.
// - Cell options come from static architecture cells, not run-time pins.
// - Three global modes restrict what each macrocell may be.
// - Narrow mode outputs drive always, no three-state control.
// - Registered cells drive the flop to the pin and feed it back.
// - Registered and wide modes allow term-gated bidirectional pins.
// - Wide mode outer cells are term-gated outputs without feedback.
// - Input cells switch the driver off; all but the two outer cells feed the pin level.
// - Registered mode: pin one clocks flops, pin eleven enables them, low.
// - Combinational modes: both special pins are plain array inputs.
// - Reset clears every flop, so active-low registered pins read high.
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sop_array (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Dedicated pins
	input wire logic [7:0] ded_i,
	input wire logic clk_pin_i,
	input wire logic oe_pin_n_i,
	// Macrocell pins
	input wire logic [7:0] cell_pin_i,
	output logic [7:0] cell_pin_o,
	output logic [7:0] cell_pin_oe_n_o
);

	// Kind of a macrocell from the mode and its own select cell, or from its position in wide mode
	function automatic pla_pkg::cell_e cell_kind(input pla_pkg::mode_e mode, input logic sel,
		input int idx);
		pla_pkg::cell_e k;
		case (mode)
			pla_pkg::MODE_NARROW: begin
				k = sel ? pla_pkg::CELL_OUTPUT : pla_pkg::CELL_INPUT;
			end
			pla_pkg::MODE_REG: begin
				k = sel ? pla_pkg::CELL_REG : pla_pkg::CELL_IO;
			end
			pla_pkg::MODE_WIDE: begin
				if (idx == 0 || idx == pla_pkg::NUM_CELLS - 1) begin
					k = pla_pkg::CELL_TRI;
				end else begin
					k = pla_pkg::CELL_IO;
				end
			end
			default: begin
				k = pla_pkg::CELL_INPUT;
			end
		endcase
		return k;
	endfunction

	// Polarity cell: 1 keeps the sum, 0 inverts it
	function automatic logic apply_pol(input logic sum, input logic act_high);
		return sum ^ ~act_high;
	endfunction

	// Word decode of one register offset; byte lanes of the address ignored
	function automatic logic word_hit(input logic [8:0] adr, input logic [8:0] base);
		return adr[8:2] == base[8:2];
	endfunction

	// Array feedback of one cell: registered cells feed the flop, others the pin
	function automatic logic feed_of(input pla_pkg::cell_e kind, input logic ff, input logic pin);
		logic r;
		if (kind == pla_pkg::CELL_REG) begin
			r = ff;
		end else begin
			r = pin;
		end
		return r;
	endfunction

	// Pin level and driver enable of one macrocell, as {pin, oe_n}
	function automatic logic [1:0] drive_of(input pla_pkg::cell_e kind, input pla_pkg::sop_s s,
		input logic act_high, input logic ff, input logic oe_pin_n);
		logic [1:0] r;
		case (kind)
			pla_pkg::CELL_OUTPUT: begin
				r = {apply_pol(s.sum8, act_high), 1'b0};
			end
			pla_pkg::CELL_REG: begin
				r = {~ff, oe_pin_n};
			end
			pla_pkg::CELL_IO, pla_pkg::CELL_TRI: begin
				r = {apply_pol(s.sum7, act_high), ~s.gate};
			end
			pla_pkg::CELL_INPUT: begin
				r = 2'b01;
			end
			default: begin
				r = 2'b01;
			end
		endcase
		return r;
	endfunction

	// Read data of one bus word; unmapped offsets read as zero
	function automatic logic [31:0] read_word(input logic [8:0] adr, input logic [31:0] cell_w,
		input logic [31:0] arch_w, input logic [31:0] stat_w);
		logic [31:0] r;
		if (!adr[pla_pkg::ARRAY_SEL_BIT]) begin
			r = cell_w;
		end else if (word_hit(adr, pla_pkg::ARCH_ADDR)) begin
			r = arch_w;
		end else if (word_hit(adr, pla_pkg::STATUS_ADDR)) begin
			r = stat_w;
		end else begin
			r = '0;
		end
		return r;
	endfunction

	// Bus request decode
	logic req;
	logic hit_array;
	logic hit_arch;
	logic hit_status;
	logic [5:0] word_idx;

	always_comb begin
		req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		word_idx = wb_adr_i[pla_pkg::IDX_LSB +: pla_pkg::IDX_W];
		hit_array = ~wb_adr_i[pla_pkg::ARRAY_SEL_BIT];
		hit_arch = word_hit(wb_adr_i, pla_pkg::ARCH_ADDR);
		hit_status = word_hit(wb_adr_i, pla_pkg::STATUS_ADDR);
	end

	// Cell storage
	logic [63:0][31:0] cells;
	logic array_we;

	assign array_we = req & wb_we_i & hit_array;

	and_array_cells u_cells (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(array_we),
		.idx_i(word_idx),
		.wdata_i(wb_dat_i),
		.sel_i(wb_sel_i),
		.cells_o(cells)
	);

	// Architecture cells
	pla_pkg::arch_s arch_q;
	pla_pkg::arch_s arch_d;
	logic [31:0] arch_word;
	logic [31:0] arch_new;

	always_comb begin
		arch_word = '0;
		arch_word[pla_pkg::ARCH_MODE_LSB +: 3] = arch_q.mode;
		arch_word[pla_pkg::ARCH_SEL_LSB +: 8] = arch_q.sel;
		arch_word[pla_pkg::ARCH_POL_LSB +: 8] = arch_q.act_high;
		arch_new = pla_pkg::merge_bytes(arch_word, wb_dat_i, wb_sel_i);
		arch_d = arch_q;
		if (req && wb_we_i && hit_arch) begin
			arch_d.sel = arch_new[pla_pkg::ARCH_SEL_LSB +: 8];
			arch_d.act_high = arch_new[pla_pkg::ARCH_POL_LSB +: 8];
			// Only the three legal mode codes are taken
			case (arch_new[pla_pkg::ARCH_MODE_LSB +: 3])
				pla_pkg::MODE_NARROW: begin
					arch_d.mode = pla_pkg::MODE_NARROW;
				end
				pla_pkg::MODE_REG: begin
					arch_d.mode = pla_pkg::MODE_REG;
				end
				pla_pkg::MODE_WIDE: begin
					arch_d.mode = pla_pkg::MODE_WIDE;
				end
				default: begin
					arch_d.mode = arch_q.mode;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arch_q <= pla_pkg::ARCH_RESET;
		end else begin
			arch_q <= arch_d;
		end
	end

	// Array input lines and feedback
	pla_pkg::cell_e kind [8];
	logic [7:0] ff_q;
	logic [7:0] ff_d;
	logic [15:0] lines;

	// Cell kinds follow the architecture cells at once
	always_comb begin
		for (int k = 0; k < pla_pkg::NUM_CELLS; k++) begin
			kind[k] = cell_kind(arch_q.mode, arch_q.sel[k], k);
		end
	end

	always_comb begin
		lines[7:0] = ded_i;
		for (int k = 0; k < pla_pkg::NUM_CELLS; k++) begin
			lines[pla_pkg::NUM_DED + k] = feed_of(kind[k], ff_q[k], cell_pin_i[k]);
		end
		// Outer feedback slots carry the special pins outside registered mode
		if (arch_q.mode != pla_pkg::MODE_REG) begin
			lines[pla_pkg::NUM_DED] = clk_pin_i;
			lines[pla_pkg::NUM_LINES - 1] = oe_pin_n_i;
		end
	end

	// Eight groups of eight terms
	pla_pkg::sop_s sop [8];

	for (genvar g = 0; g < pla_pkg::NUM_CELLS; g++) begin : g_grp
		sop_group u_grp (
			.cells_i(cells[g*pla_pkg::TERMS_PER_CELL +: pla_pkg::TERMS_PER_CELL]),
			.lines_i(lines),
			.sop_o(sop[g])
		);
	end

	// Clock pin edge; sampled as a plain synchronous input
	logic clk_pin_q;
	logic clk_pin_d;
	logic clk_edge;

	always_comb begin
		clk_pin_d = clk_pin_i;
		// A stable pin after reset yields no spurious first capture
		clk_edge = clk_pin_i & ~clk_pin_q & (arch_q.mode == pla_pkg::MODE_REG);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_pin_q <= pla_pkg::CLK_PIN_RESET;
		end else begin
			clk_pin_q <= clk_pin_d;
		end
	end

	// Macrocell flops hold the inverted pin level, so clear means high pin
	always_comb begin
		ff_d = ff_q;
		for (int k = 0; k < pla_pkg::NUM_CELLS; k++) begin
			if (clk_edge && kind[k] == pla_pkg::CELL_REG) begin
				ff_d[k] = ~apply_pol(sop[k].sum8, arch_q.act_high[k]);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ff_q <= pla_pkg::FF_RESET;
		end else begin
			ff_q <= ff_d;
		end
	end

	// Pin drivers; combinational paths see one clk_i of latency
	logic [7:0] pin_q;
	logic [7:0] pin_d;
	logic [7:0] oe_n_q;
	logic [7:0] oe_n_d;

	// One shared enable pin: registered cells cannot be enabled one by one
	always_comb begin
		for (int k = 0; k < pla_pkg::NUM_CELLS; k++) begin
			{pin_d[k], oe_n_d[k]} = drive_of(kind[k], sop[k], arch_q.act_high[k],
				ff_q[k], oe_pin_n_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= pla_pkg::PIN_RESET;
			oe_n_q <= pla_pkg::OE_N_RESET;
		end else begin
			pin_q <= pin_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign cell_pin_o = pin_q;
	assign cell_pin_oe_n_o = oe_n_q;

	// Bus answer: one cycle after the request, unmapped reads give zero
	logic ack_q;
	logic ack_d;
	logic [31:0] dat_q;
	logic [31:0] dat_d;
	logic [31:0] status_word;

	always_comb begin
		status_word = '0;
		status_word[pla_pkg::STAT_PIN_LSB +: 8] = pin_q;
		status_word[pla_pkg::STAT_OE_LSB +: 8] = oe_n_q;
		status_word[pla_pkg::STAT_FF_LSB +: 8] = ff_q;
		status_word[pla_pkg::STAT_MODE_LSB +: 3] = arch_q.mode;
		ack_d = req;
		dat_d = dat_q;
		// Data held between requests so a slow master still sees it
		if (req) begin
			dat_d = read_word(wb_adr_i, cells[word_idx], arch_word, status_word);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

endmodule
`default_nettype wire

// ==== sop_array_properties.sv ====
// Port checker for the sum-of-products array, with its bind
`timescale 1ns/100ps
`default_nettype none
module sop_array_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pins
	input wire logic clk_pin_i,
	input wire logic oe_pin_n_i,
	input wire logic [7:0] cell_pin_o,
	input wire logic [7:0] cell_pin_oe_n_o
);
	logic take;
	logic [2:0] mode_q, mode_d;
	logic [7:0] sel_q, sel_d;
	logic [1:0] calm_q, calm_d;
	logic prev_q, rise_q, rise_d, rise2_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Shadow of mode and select; calm counts edges since they last moved
	always_comb begin
		mode_d = mode_q;
		sel_d = sel_q;
		if (take && wb_we_i && wb_adr_i == pla_pkg::ARCH_ADDR) begin
			if (wb_sel_i[0] && wb_dat_i[2:0] inside {3'h1, 3'h2, 3'h4}) begin
				mode_d = wb_dat_i[2:0];
			end
			if (wb_sel_i[1]) begin
				sel_d = wb_dat_i[15:8];
			end
		end
		calm_d = (mode_d != mode_q || sel_d != sel_q) ? 2'h0 : calm_q + {1'b0, ~&calm_q};
		rise_d = clk_pin_i & ~prev_q;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= 3'h1;
			sel_q <= 8'h00;
			calm_q <= 2'h3;
			prev_q <= 1'b1;
			rise_q <= 1'b0;
			rise2_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			sel_q <= sel_d;
			calm_q <= calm_d;
			prev_q <= clk_pin_i;
			rise_q <= rise_d;
			rise2_q <= rise_q;
		end
	end
	chk_ack_once: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after request");
	chk_ack_cause: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i >= 9'h108 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_mode_read: assert property (take && !wb_we_i && wb_adr_i == pla_pkg::STATUS_ADDR
		|=> wb_dat_o[26:24] == mode_q)
		else $error("status mode differs");
	chk_reset_idle: assert property ($fell(rst_i) |-> cell_pin_o == 8'h00 && cell_pin_oe_n_o == 8'hFF)
		else $error("pins not idle after reset");
	chk_narrow_oe: assert property (mode_q == 3'h1 && calm_q[1] |-> cell_pin_oe_n_o == ~sel_q)
		else $error("narrow mode enables wrong");
	chk_reg_oe: assert property (mode_q == 3'h2 && calm_q[1]
		|-> ((cell_pin_oe_n_o ^ {8{$past(oe_pin_n_i)}}) & sel_q) == 8'h00)
		else $error("registered enable not following pin");
	chk_reg_hold: assert property (mode_q == 3'h2 && calm_q[1] && !rise_q && !rise2_q
		|-> ((cell_pin_o ^ $past(cell_pin_o)) & sel_q) == 8'h00)
		else $error("registered pin moved without clock");
endmodule
bind sop_array sop_array_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clk_pin_i(clk_pin_i),
	.oe_pin_n_i(oe_pin_n_i), .cell_pin_o(cell_pin_o), .cell_pin_oe_n_o(cell_pin_oe_n_o));
`default_nettype wire

// ==== board_link.sv ====
// Board model resolving each macrocell pin wire
`timescale 1ns/100ps
`default_nettype none
module board_link (
	// Device side
	input wire logic [7:0] dev_pin_i,
	input wire logic [7:0] dev_oe_n_i,
	// Board level on released pins
	input wire logic [7:0] ext_i,
	// Wire level
	output logic [7:0] wire_o
);
	// Board drives only released pins, so no contention
	assign wire_o = (dev_pin_i & ~dev_oe_n_i) | (ext_i & dev_oe_n_i);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the sum-of-products array
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_i, rst_i, cyc, stb, we, clk_pin, oe_pin_n, wb_ack_o;
	logic [8:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, wb_dat_o;
	logic [7:0] ded, ext, pin_i, pin_o, oe_n;
	logic [2:0] codes [4] = '{3'h2, 3'h4, 3'h3, 3'h1};
	logic [2:0] modes [4] = '{3'h2, 3'h4, 3'h4, 3'h1};
	int errors, compares;
	sop_array u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ded_i(ded), .clk_pin_i(clk_pin), .oe_pin_n_i(oe_pin_n), .cell_pin_i(pin_i),
		.cell_pin_o(pin_o), .cell_pin_oe_n_o(oe_n));
	board_link u_board (.dev_pin_i(pin_o), .dev_oe_n_i(oe_n), .ext_i(ext), .wire_o(pin_i));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Three edges: one to sample, one pipeline stage, one spare
	task automatic step(input logic [7:0] d, input logic c, input logic g);
		@(posedge clk_i);
		ded <= d;
		clk_pin <= c;
		oe_pin_n <= g;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		errors++;
		wrap_up();
	end
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 9'h000;
		sel = 4'hF;
		dat = 32'h0;
		ded = 8'h00;
		ext = 8'hA5;
		clk_pin = 1'b1;
		oe_pin_n = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 9'h100, 0); chk(rdat, 32'h00FF0001);
		bus(0, 9'h104, 0); chk(rdat, 32'h0100FF00);
		$display("reset test done");
		bus(1, 9'h000, 32'h00000001);
		bus(1, 9'h020, 32'h00000001);
		bus(1, 9'h024, 32'h00000002);
		bus(1, 9'h100, 32'h00010101);
		step(8'h01, 1, 1); chk({oe_n[1:0], pin_o[0]}, 3'h5);
		step(8'h00, 1, 1); chk({oe_n[1:0], pin_o[0]}, 3'h4);
		bus(1, 9'h100, 32'h00000101);
		step(8'h00, 1, 1); chk({oe_n[1:0], pin_o[0]}, 3'h5);
		bus(1, 9'h100, 32'h00010101);
		bus(1, 9'h000, 32'h00010000);
		step(8'h00, 1, 1); chk({oe_n[1:0], pin_o[0]}, 3'h5);
		bus(1, 9'h000, 32'h00000100);
		step(8'h00, 0, 1); chk({oe_n[1:0], pin_o[0]}, 3'h4);
		step(8'h00, 1, 1); chk({oe_n[1:0], pin_o[0]}, 3'h5);
		bus(1, 9'h000, 32'h00000001);
		$display("narrow test done");
		for (int i = 0; i < 4; i++) begin
			bus(1, 9'h100, {8'h00, 8'h01, 8'h01, 5'h00, codes[i]});
			bus(0, 9'h104, 0); chk(rdat[26:24], modes[i]);
		end
		$display("mode test done");
		bus(1, 9'h100, 32'h00030102);
		step(8'h00, 0, 0); chk({oe_n[1:0], pin_o[0]}, 3'h5);
		step(8'h00, 1, 0); chk({oe_n[1:0], pin_o[0]}, 3'h4);
		step(8'h03, 1, 0); chk({oe_n[1:0], pin_o[1:0]}, 4'h2);
		step(8'h03, 0, 0);
		step(8'h03, 1, 0); chk({oe_n[1:0], pin_o[1:0]}, 4'h3);
		step(8'h02, 1, 1); chk({oe_n[1:0], pin_o[0]}, 3'h7);
		$display("registered test done");
		bus(1, 9'h100, 32'h00030104);
		step(8'h03, 1, 1); chk({oe_n[1:0], pin_o[1:0]}, 4'h2);
		step(8'h02, 1, 1); chk(oe_n[1:0], 2'h3);
		bus(0, 9'h108, 0); chk(rdat, 32'h0);
		bus(1, 9'h104, 32'hFFFFFFFF);
		bus(0, 9'h104, 0); chk(rdat[26:24], 3'h4);
		$display("wide test done");
		wrap_up();
	end
endmodule
`default_nettype wire
